// ---- core/bmmd_gpr_ram.v ----
// General purpose static RAM: synchronous write, combinational read
`timescale 1ns/1ps
module bmmd_gpr_ram #(
   parameter DW = 8,
   parameter AW = 7,
   parameter DEPTH = 128
) (
   input wire ref_clk,
   input wire wrEn,
   input wire [AW-1:0] wrAddr,
   input wire [DW-1:0] wrData,
   input wire [AW-1:0] rdAddr,
   output wire [DW-1:0] rdData
);
   // Storage array, no reset: contents are undefined after power-up
   reg [DW-1:0] mem [0:DEPTH-1];

   // Write port
   always @(posedge ref_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Read port is asynchronous; the caller registers the result
   assign rdData = mem[rdAddr];
endmodule

// ---- core/bmmd_map_top.v ----
// Banked data memory decoder, program counter and AHB-Lite register slave
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "bmmd_regs.vh"

//
// Overview of operation
// - Thirteen-bit program counter spans 8k words
// - Only the lowest 2k program words exist
// - Fetch addresses above 2k wrap around
// - Fetch starts at address zero after reset
// - Taken interrupt redirects fetch to 0004h
// - Two banks, lowest 32 addresses are special
// - RAM at 20h-7Fh and A0h-BFh
// - Bank one F0h-FFh shares 70h-7Fh storage
// - Unimplemented data locations read as zero
// - Status bit five selects the data bank
// - 128 bytes reachable directly or through pointer
// - Special registers keep values between accesses
module bmmd_map_top (
   input wire ref_clk,
   input wire nrst,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Core fetch side
   input wire fetchNext,
   input wire jumpValid,
   input wire [12:0] jumpAddr,
   input wire intTake,
   output wire [10:0] progAddr,
   output wire [12:0] pcValue,
   // Core data side
   input wire dValid,
   input wire dWrite,
   input wire [6:0] dAddr,
   input wire [7:0] dWdata,
   output reg [7:0] dRdata,
   output wire bankSel
);
   // Source selector for the single storage access port
   localparam SRC_NONE = 2'b00;
   localparam SRC_CORE = 2'b01;
   localparam SRC_BUS = 2'b10;

   // Architectural registers
   reg [12:0] pc_reg; // Full program counter
   reg [12:0] pc_next;
   reg [7:0] status_reg; // Status, bank bit included
   reg [7:0] status_next;
   reg [7:0] pointer_reg; // File select pointer
   reg [7:0] pointer_next;
   reg [7:0] program_counter_high_latch_reg; // Upper program counter write buffer
   reg [7:0] program_counter_high_latch_next;
   // Peripheral special register storage, both banks
   reg [7:0] sfrMem [0:63];

   // Bus slave state
   reg busPend_reg; // Data phase in progress
   reg busDone_reg; // Data phase finishing this cycle
   reg busWrite_reg;
   reg [6:0] busIdx_reg; // Word index of the pending transfer

   // Access port signals
   reg [1:0] accSrc;
   reg [7:0] accAddr; // Effective 8-bit data address
   reg accWr;
   reg [7:0] accWdata;
   reg [7:0] accRdata;
   reg accValidAddr; // False when the window points at itself
   wire [7:0] ramRdata;
   wire ramWe;
   wire [6:0] ramIdx;
   wire busAccept;
   wire busSlot;
   // Unimplemented special slots, one bit per {bank, addr[4:0]}
   wire [63:0] sfrUnimpl = `BMMD_SFR_UNIMPL;

   // True for the general purpose RAM ranges, including the shared window
   function isGpr;
      input [7:0] ea;
      begin
         isGpr = ((ea >= `BMMD_GPR0_LO) && (ea <= `BMMD_GPR0_HI)) ||
                 ((ea >= `BMMD_GPR1_LO) && (ea <= `BMMD_GPR1_HI)) ||
                 (ea >= `BMMD_SHARED_LO);
      end
   endfunction

   // Map an effective address onto one of the 128 RAM bytes
   function [6:0] gprIndex;
      input [7:0] ea;
      reg [7:0] t;
      begin
         t = 8'h00;
         if (ea >= `BMMD_SHARED_LO) begin
            t = ea - `BMMD_SHARED_LO + `BMMD_SHARED_BASE - `BMMD_GPR0_LO;
         end else if (ea[7]) begin
            t = ea - `BMMD_GPR1_LO + {1'b0, `BMMD_GPR1_RAM_BASE};
         end else begin
            t = ea - `BMMD_GPR0_LO;
         end
         gprIndex = t[6:0];
      end
   endfunction

   // Lowest 32 addresses of either bank are special registers
   function isSfr;
      input [7:0] ea;
      begin
         isSfr = (ea[6:0] <= {2'b00, `BMMD_SFR_TOP});
      end
   endfunction

   // Core registers that appear in both banks
   function isCoreReg;
      input [7:0] ea;
      begin
         isCoreReg = (ea[6:0] == `BMMD_IDX_PCL) || (ea[6:0] == `BMMD_IDX_STATUS) ||
                     (ea[6:0] == `BMMD_IDX_POINTER) || (ea[6:0] == `BMMD_IDX_PROGRAM_COUNTER_HIGH_LATCH);
      end
   endfunction

   // Bank bit and fetch address
   assign bankSel = status_reg[`BMMD_STATUS_BANK];
   assign pcValue = pc_reg;
   assign progAddr = pc_reg[`BMMD_PROG_IMPL_W-1:0];

   // Bus transfer accepted in address phase
   assign busAccept = hsel && htrans[1] && hready;
   // Bus uses the access port only when the core is idle
   assign busSlot = busPend_reg && !busDone_reg && !dValid;
   // Wait state while a data phase has not completed; always OKAY
   assign hreadyout = !busPend_reg || busDone_reg;
   assign hresp = 1'b0;

   // Choose source and form effective address
   always @* begin
      accSrc = SRC_NONE;
      accAddr = 8'h00;
      accWr = 1'b0;
      accWdata = 8'h00;
      accValidAddr = 1'b1;
      if (dValid) begin
         // Core has priority; the bus waits
         accSrc = SRC_CORE;
         accAddr = {status_reg[`BMMD_STATUS_BANK], dAddr};
         accWr = dWrite;
         accWdata = dWdata;
      end else if (busSlot) begin
         accSrc = SRC_BUS;
         accAddr = {status_reg[`BMMD_STATUS_BANK], busIdx_reg};
         accWr = busWrite_reg;
         accWdata = hwdata[7:0];
      end
      // Window location redirects through the pointer
      if (accAddr[6:0] == `BMMD_IDX_WINDOW) begin
         accAddr = pointer_reg;
         // Window through itself is not a physical register
         accValidAddr = (pointer_reg[6:0] != `BMMD_IDX_WINDOW);
      end
   end

   // Bus reaches only the window, the core registers and PCFULL; PCFULL is outside the data map
   wire busIsPc = (accSrc == SRC_BUS) && (busIdx_reg == `BMMD_IDX_PCFULL);
   wire busUnmapped = (accSrc == SRC_BUS) && (busIdx_reg != `BMMD_IDX_WINDOW) &&
                      !isCoreReg({1'b0, busIdx_reg}) && !busIsPc;
   wire accLive = (accSrc != SRC_NONE) && accValidAddr && !busIsPc && !busUnmapped;

   // RAM write enable and index
   assign ramWe = accLive && accWr && isGpr(accAddr);
   assign ramIdx = gprIndex(accAddr);

   bmmd_gpr_ram #(
      .DW(8),
      .AW(7),
      .DEPTH(128)
   ) uRam (
      .ref_clk(ref_clk),
      .wrEn(ramWe),
      .wrAddr(ramIdx),
      .wrData(accWdata),
      .rdAddr(ramIdx),
      .rdData(ramRdata)
   );

   // Read multiplexer over the whole data map
   always @* begin
      accRdata = 8'h00;
      if (accLive) begin
         if (isSfr(accAddr)) begin
            case (accAddr[6:0])
               `BMMD_IDX_PCL: accRdata = pc_reg[7:0];
               `BMMD_IDX_STATUS: accRdata = status_reg;
               `BMMD_IDX_POINTER: accRdata = pointer_reg;
               `BMMD_IDX_PROGRAM_COUNTER_HIGH_LATCH: accRdata = {3'b000, program_counter_high_latch_reg[4:0]};
               default: begin
                  // Unimplemented slots read as zero
                  if (!sfrUnimpl[{accAddr[7], accAddr[4:0]}]) begin
                     accRdata = sfrMem[{accAddr[7], accAddr[4:0]}];
                  end else begin
                     accRdata = 8'h00;
                  end
               end
            endcase
         end else if (isGpr(accAddr)) begin
            accRdata = ramRdata;
         end else begin
            accRdata = 8'h00;
         end
      end
   end

   // Next values of the core registers
   always @* begin
      status_next = status_reg;
      pointer_next = pointer_reg;
      program_counter_high_latch_next = program_counter_high_latch_reg;
      pc_next = pc_reg;
      // Fetch sequencing: increment wraps in thirteen bits
      if (fetchNext) begin
         pc_next = pc_reg + 13'h0001;
      end
      if (jumpValid) begin
         pc_next = jumpAddr;
      end
      if (accLive && accWr && isSfr(accAddr)) begin
         case (accAddr[6:0])
            `BMMD_IDX_PCL: begin
               // Low byte write loads the upper bits from the buffer
               pc_next = {program_counter_high_latch_reg[4:0], accWdata};
            end
            `BMMD_IDX_STATUS: begin
               // Reserved bits stored as written; keeping them zero is software's job
               status_next = accWdata;
            end
            `BMMD_IDX_POINTER: pointer_next = accWdata;
            `BMMD_IDX_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_next = {3'b000, accWdata[4:0]};
            default: program_counter_high_latch_next = program_counter_high_latch_reg;
         endcase
      end
      // Interrupt wins over every other redirect
      if (intTake) begin
         pc_next = `BMMD_INT_VECTOR;
      end
   end

   // Core register update
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pc_reg <= `BMMD_RESET_VECTOR;
         status_reg <= `BMMD_RST_STATUS;
         pointer_reg <= `BMMD_RST_POINTER;
         program_counter_high_latch_reg <= `BMMD_RST_PROGRAM_COUNTER_HIGH_LATCH;
      end else begin
         pc_reg <= pc_next;
         status_reg <= status_next;
         pointer_reg <= pointer_next;
         program_counter_high_latch_reg <= program_counter_high_latch_next;
      end
   end

   // Peripheral special register storage, holds value between accesses
   always @(posedge ref_clk) begin
      if (accLive && accWr && isSfr(accAddr) && !isCoreReg(accAddr)) begin
         sfrMem[{accAddr[7], accAddr[4:0]}] <= accWdata;
      end
   end

   // Core read data, one cycle after the request
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dRdata <= 8'h00;
      end else if (accSrc == SRC_CORE && !accWr) begin
         dRdata <= accRdata;
      end
   end

   // Bus slave sequencing: one wait state at least, more while the core is busy
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         busPend_reg <= 1'b0;
         busDone_reg <= 1'b0;
         busWrite_reg <= 1'b0;
         busIdx_reg <= 7'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         if (busAccept) begin
            // New address phase, only possible when the bus is ready
            busPend_reg <= 1'b1;
            busDone_reg <= 1'b0;
            busWrite_reg <= hwrite;
            busIdx_reg <= haddr[8:2];
         end else if (busDone_reg) begin
            busPend_reg <= 1'b0;
            busDone_reg <= 1'b0;
         end else if (busSlot) begin
            busDone_reg <= 1'b1;
            if (busIsPc) begin
               hrdata <= {19'h00000, pc_reg};
            end else begin
               hrdata <= {24'h000000, accRdata};
            end
         end
      end
   end
endmodule

// ---- pkg/bmmd_regs.vh ----
// Constants of the banked memory map decoder: offsets, fields, resets, ranges
`ifndef BMMD_REGS_VH
`define BMMD_REGS_VH

// Register indices as placed in the data map (byte address is four times the index)
`define BMMD_IDX_WINDOW 7'h00
`define BMMD_IDX_PCL 7'h02
`define BMMD_IDX_STATUS 7'h03
`define BMMD_IDX_POINTER 7'h04
`define BMMD_IDX_PROGRAM_COUNTER_HIGH_LATCH 7'h0A
`define BMMD_IDX_PCFULL 7'h10
// Bus byte addresses derived from the indices
`define BMMD_ADDR_OF(idx) ({idx, 2'b00})

// Status field positions
`define BMMD_STATUS_BANK 5
`define BMMD_STATUS_RSVD_LO 6
`define BMMD_STATUS_RSVD_HI 7

// Reset values
`define BMMD_RST_STATUS 8'h18
`define BMMD_RST_POINTER 8'h00
`define BMMD_RST_PROGRAM_COUNTER_HIGH_LATCH 8'h00
`define BMMD_RESET_VECTOR 13'h0000
`define BMMD_INT_VECTOR 13'h0004

// Program memory geometry
`define BMMD_PC_W 13
`define BMMD_PROG_IMPL_W 11

// Data memory ranges (8-bit effective addresses)
`define BMMD_SFR_TOP 5'h1F
`define BMMD_GPR0_LO 8'h20
`define BMMD_GPR0_HI 8'h7F
`define BMMD_GPR1_LO 8'hA0
`define BMMD_GPR1_HI 8'hBF
`define BMMD_SHARED_LO 8'hF0
`define BMMD_SHARED_HI 8'hFF
`define BMMD_SHARED_BASE 8'h70
`define BMMD_GPR1_RAM_BASE 7'h60

// Unimplemented special register slots, bit index {bank, addr[4:0]}
`define BMMD_SFR_UNIMPL 64'h01982300_38002300

`endif

// ---- sim/bmmd_core_model.sv ----
// Processor core model: fetch control and byte data accesses
`timescale 1ns/1ps
module bmmd_core_model (
   input wire ref_clk,
   output reg fetchNext,
   output reg jumpValid,
   output reg [12:0] jumpAddr,
   output reg intTake,
   output reg dValid,
   output reg dWrite,
   output reg [6:0] dAddr,
   output reg [7:0] dWdata
);
   initial begin
      {fetchNext, jumpValid, intTake, dValid, dWrite} = 5'h00;
      jumpAddr = 13'h0000;
      dAddr = 7'h00;
      dWdata = 8'h00;
   end
   // One-cycle fetch pulse: 0 step, 1 jump, 2 interrupt
   task pc(input int kind, input [12:0] a);
      @(posedge ref_clk);
      fetchNext <= (kind == 0);
      jumpValid <= (kind == 1);
      intTake <= (kind == 2);
      jumpAddr <= a;
      @(posedge ref_clk);
      {fetchNext, jumpValid, intTake} <= 3'h0;
      jumpAddr <= ~a; // Released target keeps changing
   endtask
   // Single byte access, taken at the next edge
   task acc(input bit we, input [6:0] a, input [7:0] d);
      @(posedge ref_clk);
      dValid <= 1'b1;
      dWrite <= we;
      dAddr <= a;
      dWdata <= d;
      @(posedge ref_clk);
      dValid <= 1'b0;
      dAddr <= ~a; // Idle lines do not hold the old value
      dWdata <= ~d;
   endtask
endmodule

// ---- sim/bmmd_map_bench.sv ----
// Self-checking bench of the banked memory map decoder
`timescale 1ns/1ps
`include "bmmd_regs.vh"
module bmmd_map_bench;
   reg ref_clk, nrst, hsel, hwrite;
   reg [31:0] haddr, hwdata;
   reg [1:0] htrans;
   reg [2:0] hsize;
   wire hreadyout, hresp, fetchNext, jumpValid, intTake, dValid, dWrite, bankSel;
   wire [31:0] hrdata;
   wire [12:0] jumpAddr, pcValue;
   wire [10:0] progAddr;
   wire [6:0] dAddr;
   wire [7:0] dWdata, dRdata;
   int failures = 0, samplesChecked = 0;
   int ram[256]; // Model of the RAM, indexed by folded address
   bmmd_map_top dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fetchNext(fetchNext),
      .jumpValid(jumpValid), .jumpAddr(jumpAddr), .intTake(intTake), .progAddr(progAddr),
      .pcValue(pcValue), .dValid(dValid), .dWrite(dWrite), .dAddr(dAddr), .dWdata(dWdata),
      .dRdata(dRdata), .bankSel(bankSel));
   bmmd_core_model core (.ref_clk(ref_clk), .fetchNext(fetchNext), .jumpValid(jumpValid),
      .jumpAddr(jumpAddr), .intTake(intTake), .dValid(dValid), .dWrite(dWrite),
      .dAddr(dAddr), .dWdata(dWdata));
   // Compare one value against the model
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d failures %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Single word transfer; ready sampled at each rising edge, data taken there
   task ahb(input bit we, input [6:0] idx, input [7:0] wd, output [31:0] rd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= we;
      haddr <= {23'h0, idx, 2'b00};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check(hresp, 1'b0);
   endtask
   // Shared top of bank one lands on bank zero storage
   function int fold(input int ea);
      return (ea >= 8'hF0) ? ea - 8'h80 : ea;
   endfunction
   // Core read compared against an expected byte
   task dchk(input [6:0] a, input [7:0] e);
      core.acc(1'b0, a, 8'h00);
      #1 check(dRdata, e);
   endtask
   initial begin
      ref_clk = 0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Watchdog well beyond the expected run
   initial begin
      #200000 failures++;
      finish_test;
   end
   initial begin
      logic [31:0] rd;
      int ea, d;
      {nrst, hsel, hwrite, htrans} = 5'h00;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      ea = $urandom(36708);
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      #1 check(pcValue, 13'h0000);
      ahb(0, `BMMD_IDX_STATUS, 0, rd);
      check(rd[7:0], 8'h18);
      core.pc(1, 13'h0FFF);
      #1 check(progAddr, 11'h7FF);
      core.pc(0, 0);
      #1 check({pcValue, progAddr}, {13'h1000, 11'h000});
      core.pc(2, 0);
      #1 check(pcValue, 13'h0004);
      for (int b = 0; b < 2; b++) begin
         ahb(1, `BMMD_IDX_STATUS, b ? 8'h38 : 8'h18, rd);
         #1 check(bankSel, b);
         // Known contents for the shared window and the pointer targets
         if (b) begin
            for (int a = 8'hF0; a <= 8'hFF; a++) begin
               core.acc(1'b1, a[6:0], a[7:0] ^ 8'h96);
               ram[fold(a)] = a[7:0] ^ 8'h96;
            end
         end else begin
            core.acc(1'b1, 7'h30, 8'hA5);
            ram[8'h30] = 8'hA5;
            core.acc(1'b1, 7'h78, 8'h5C);
            ram[8'h78] = 8'h5C;
         end
         repeat (12) begin
            ea = b ? (($urandom % 2) ? 8'hA0 + $urandom % 32 : 8'hF0 + $urandom % 16)
               : 8'h20 + $urandom % 96;
            d = $urandom % 256;
            core.acc(1'b1, ea[6:0], d[7:0]);
            ram[fold(ea)] = d;
            dchk(ea[6:0], d[7:0]);
         end
         // Written holes must still read as zero
         core.acc(1'b1, b ? 7'h45 : 7'h08, 8'hFF);
         dchk(b ? 7'h45 : 7'h08, 8'h00);
         // Peripheral slot keeps its value, separately per bank
         core.acc(1'b1, 7'h0B, b ? 8'hC3 : 8'h3C);
         dchk(7'h0B, b ? 8'hC3 : 8'h3C);
         core.acc(1'b1, 7'h04, b ? 8'h30 : 8'hF8);
         dchk(7'h00, ram[fold(b ? 8'h30 : 8'hF8)]);
         ahb(0, `BMMD_IDX_POINTER, 0, rd);
         check(rd[7:0], b ? 8'h30 : 8'hF8);
      end
      ahb(1, `BMMD_IDX_STATUS, 8'h18, rd);
      for (int a = 8'h70; a < 8'h80; a++) dchk(a[6:0], ram[a]);
      dchk(7'h0B, 8'h3C);
      ahb(1, 7'h3F, 8'h5A, rd);
      ahb(0, 7'h3F, 0, rd);
      check(rd, 32'h0);
      finish_test;
   end
endmodule
bind bmmd_map_top bmmd_map_props chk (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
   .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .fetchNext(fetchNext),
   .jumpValid(jumpValid), .jumpAddr(jumpAddr), .intTake(intTake), .progAddr(progAddr),
   .pcValue(pcValue), .dValid(dValid), .dWrite(dWrite), .dAddr(dAddr), .dRdata(dRdata),
   .bankSel(bankSel));

// ---- sim/bmmd_map_props.sv ----
// Checker for fetch, data and bus behaviour of the decoder
`timescale 1ns/1ps
module bmmd_map_props (
   input wire ref_clk,
   input wire nrst,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hready,
   input wire hreadyout,
   input wire fetchNext,
   input wire jumpValid,
   input wire [12:0] jumpAddr,
   input wire intTake,
   input wire [10:0] progAddr,
   input wire [12:0] pcValue,
   input wire dValid,
   input wire dWrite,
   input wire [6:0] dAddr,
   input wire [7:0] dRdata,
   input wire bankSel
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // No register write can land in this cycle
   wire quiet = hreadyout && !dValid;
   // Core read request
   wire coreRd = dValid && !dWrite;
   // Bus address phase accepted, then a bounded wait
   sequence busTake; hsel && htrans[1] && hready; endsequence
   sequence waitDone; !hreadyout ##[1:40] hreadyout; endsequence
   chk_reset_start: assert property (!$past(nrst) |-> pcValue == 13'h0000)
      else $error("fetch not at zero after reset");
   chk_int_vector: assert property (intTake |=> pcValue == 13'h0004)
      else $error("interrupt vector wrong");
   chk_prog_wrap: assert property (progAddr == pcValue[10:0])
      else $error("program address does not wrap");
   chk_fetch_step: assert property (fetchNext && !jumpValid && !intTake && quiet
      |=> pcValue == $past(pcValue) + 13'h0001)
      else $error("counter step wrong");
   chk_jump_load: assert property (jumpValid && !intTake && quiet
      |=> pcValue == $past(jumpAddr))
      else $error("jump target not loaded");
   chk_bank_hold: assert property (quiet |=> $stable(bankSel))
      else $error("bank bit moved without a write");
   chk_bus_wait: assert property (busTake |=> waitDone)
      else $error("bus transfer did not complete");
   chk_ram_hole: assert property (coreRd && bankSel && dAddr >= 7'h40 && dAddr < 7'h70
      |=> dRdata == 8'h00)
      else $error("bank one hole not zero");
   chk_sfr_hole: assert property (coreRd && !bankSel && (dAddr == 7'h08 || dAddr == 7'h09)
      |=> dRdata == 8'h00)
      else $error("empty special slot not zero");
   chk_read_hold: assert property (!coreRd |=> $stable(dRdata))
      else $error("read data changed without a read");
endmodule
